// >>> inc/cpdec_map.vh
// opcode decode constants, cycle costs and flag positions for the decoder
`ifndef CPDEC_MAP_VH
`define CPDEC_MAP_VH
// condition code bit positions
`define CPDEC_CC_C 0
`define CPDEC_CC_V 1
`define CPDEC_CC_Z 2
`define CPDEC_CC_N 3
`define CPDEC_CC_H 5
`define CPDEC_CC_I 7
// first opcode byte values and groups
`define CPDEC_OP_NOP 8'h00
`define CPDEC_OP_EXTADD_R 8'h0E
`define CPDEC_OP_DAA 8'h0F
`define CPDEC_OP_EXTSUB_R 8'h1E
`define CPDEC_OP_DAS 8'h1F
`define CPDEC_OP_ADDW 8'h09
`define CPDEC_OP_SUBW 8'h19
`define CPDEC_OP_DIVU 8'h51
`define CPDEC_OP_RTS 8'h54
`define CPDEC_OP_RTE 8'h56
`define CPDEC_OP_JSR_R 8'h5D
`define CPDEC_OP_JSR_A 8'h5E
`define CPDEC_OP_JSR_I 8'h5F
`define CPDEC_OP_MOVE_SYNC 8'h6A
`define CPDEC_OP_BLKMOVE 8'h7B
`define CPDEC_HI_BRANCH 4'h4
`define CPDEC_HI_EXTADD_I 4'h9
`define CPDEC_HI_EXTSUB_I 4'hB
`define CPDEC_HI_MOVE_I 4'hF
`define CPDEC_HI_MOVE_A 4'h2
`define CPDEC_HI_MOVE_B 4'h3
`define CPDEC_HI_MOVE_R 4'h6
// lower nibble of second byte that marks a synchronised move
`define CPDEC_SYNC_SUB 4'h0
// per-cycle state costs, on-chip placement
`define CPDEC_S_FETCH 8'h02
`define CPDEC_S_BRREAD 8'h02
`define CPDEC_S_STACK 8'h02
`define CPDEC_S_BYTE 8'h02
`define CPDEC_S_WORD 8'h02
`define CPDEC_S_INT 8'h02
// block move: 4n+8
`define CPDEC_BLK_MUL 16'h0004
`define CPDEC_BLK_ADD 16'h0008
`define CPDEC_SP_STEP 16'h0002
`define CPDEC_CC_RESET 8'h80
`define CPDEC_SP_RESET 16'h0000
`endif

// >>> rtl/cpdec_core.v
// opcode decode, special flag rules, stack sequencing and state counting
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "cpdec_map.vh"
module cpdec_core #(
   parameter SYNC_CW = 8
) (
   input wire clock,
   input wire rst,
   input wire issue,
   input wire [15:0] instr_word,
   input wire [15:0] operand_a,
   input wire [15:0] operand_b,
   input wire [7:0] count_register_low_byte,
   input wire [15:0] target_addr,
   input wire [15:0] next_pc,
   input wire [15:0] stack_rdata,
   input wire periph_clk_in,
   output reg [7:0] op_class_q,
   output reg is_sync_move_q,
   output reg is_data_move_q,
   output reg [7:0] condition_code_register_q,
   output reg [15:0] result_q,
   output reg [15:0] states_q,
   output reg [15:0] sp_q,
   output reg [15:0] pc_q,
   output reg stack_we,
   output reg [15:0] stack_addr,
   output reg [15:0] stack_wdata,
   output wire busy,
   output reg done_q
);
   localparam ST_IDLE = 3'd0;
   localparam ST_CALL = 3'd1;
   localparam ST_RET = 3'd2;
   localparam ST_RTE_CC = 3'd3;
   localparam ST_RTE_PC = 3'd4;
   localparam ST_SYNC = 3'd5;
   localparam ST_COUNT = 3'd6;

   localparam CL_OTHER = 8'h00;
   localparam CL_MOVE = 8'h01;
   localparam CL_SYNC = 8'h02;
   localparam CL_BRANCH = 8'h03;
   localparam CL_CALL = 8'h04;
   localparam CL_RTS = 8'h05;
   localparam CL_RTE = 8'h06;
   localparam CL_ADDW = 8'h07;
   localparam CL_SUBW = 8'h08;
   localparam CL_EXTADD = 8'h09;
   localparam CL_EXTSUB = 8'h0A;
   localparam CL_DAA = 8'h0B;
   localparam CL_DAS = 8'h0C;
   localparam CL_DIVU = 8'h0D;
   localparam CL_BLKMOVE = 8'h0E;

   reg [2:0] st_q;
   reg [2:0] st_d;

   // cycle-weighted total; counts i..n for the six cycle kinds
   function [15:0] weigh;
      input [3:0] i;
      input [3:0] j;
      input [3:0] k;
      input [3:0] l;
      input [3:0] m;
      input [3:0] n;
      begin
         weigh = {12'h000, i} * {8'h00, `CPDEC_S_FETCH}
            + {12'h000, j} * {8'h00, `CPDEC_S_BRREAD}
            + {12'h000, k} * {8'h00, `CPDEC_S_STACK}
            + {12'h000, l} * {8'h00, `CPDEC_S_BYTE}
            + {12'h000, m} * {8'h00, `CPDEC_S_WORD}
            + {12'h000, n} * {8'h00, `CPDEC_S_INT};
      end
   endfunction

   // class decode from first byte, bit 7 and the low nibble
   function [7:0] classify;
      input [15:0] w;
      reg [7:0] hi;
      begin
         hi = w[15:8];
         classify = CL_OTHER;
         if (hi[7:4] == `CPDEC_HI_BRANCH)
            classify = CL_BRANCH;
         else if (hi == `CPDEC_OP_JSR_R || hi == `CPDEC_OP_JSR_A || hi == `CPDEC_OP_JSR_I)
            classify = CL_CALL;
         else if (hi == `CPDEC_OP_RTS)
            classify = CL_RTS;
         else if (hi == `CPDEC_OP_RTE)
            classify = CL_RTE;
         else if (hi == `CPDEC_OP_ADDW)
            classify = CL_ADDW;
         else if (hi == `CPDEC_OP_SUBW)
            classify = CL_SUBW;
         else if (hi == `CPDEC_OP_EXTADD_R || hi[7:4] == `CPDEC_HI_EXTADD_I)
            classify = CL_EXTADD;
         else if (hi == `CPDEC_OP_EXTSUB_R || hi[7:4] == `CPDEC_HI_EXTSUB_I)
            classify = CL_EXTSUB;
         else if (hi == `CPDEC_OP_DAA)
            classify = CL_DAA;
         else if (hi == `CPDEC_OP_DAS)
            classify = CL_DAS;
         else if (hi == `CPDEC_OP_DIVU)
            classify = CL_DIVU;
         else if (hi == `CPDEC_OP_BLKMOVE && !w[7])
            classify = CL_BLKMOVE;
         else if (hi == `CPDEC_OP_MOVE_SYNC && !w[7] && w[3:0] == `CPDEC_SYNC_SUB)
            classify = CL_SYNC;
         else if (hi[7:4] == `CPDEC_HI_MOVE_I || hi[7:4] == `CPDEC_HI_MOVE_A
                  || hi[7:4] == `CPDEC_HI_MOVE_B || hi[7:4] == `CPDEC_HI_MOVE_R)
            classify = CL_MOVE;
      end
   endfunction

   // carry or borrow out of bit 11 for word add and subtract
   function half12;
      input [15:0] x;
      input [15:0] y;
      input sub;
      reg [12:0] s;
      begin
         s = sub ? ({1'b0, x[11:0]} - {1'b0, y[11:0]})
            : ({1'b0, x[11:0]} + {1'b0, y[11:0]});
         half12 = s[12];
      end
   endfunction

   // byte add or subtract with carry in; bit 8 is the carry or borrow out
   function [8:0] ext_op;
      input [7:0] x;
      input [7:0] y;
      input c;
      input sub;
      begin
         if (sub)
            ext_op = {1'b0, x} - {1'b0, y} - {8'h00, c};
         else
            ext_op = {1'b0, x} + {1'b0, y} + {8'h00, c};
      end
   endfunction

   // remainder in the high byte, quotient in the low byte
   function [15:0] div_pack;
      input [15:0] dividend;
      input [7:0] divisor;
      reg [15:0] quo;
      reg [15:0] rem;
      begin
         quo = dividend / {8'h00, divisor};
         rem = dividend % {8'h00, divisor};
         // a quotient wider than a byte is cut; callers never pass a zero divisor
         div_pack = {rem[7:0], quo[7:0]};
      end
   endfunction

   wire [7:0] cls = classify(instr_word);
   // a request raised while busy is dropped, not queued
   wire take = issue && (st_q == ST_IDLE);
   wire sync_done;
   wire [SYNC_CW-1:0] sync_waited;

   cpdec_sync_wait #(
      .CW(SYNC_CW)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .start(take && cls == CL_SYNC),
      .periph_clk_in(periph_clk_in),
      .done(sync_done),
      .waited_q(sync_waited)
   );

   assign busy = (st_q != ST_IDLE);

   // arithmetic helpers
   wire [16:0] add_w = {1'b0, operand_a} + {1'b0, operand_b};
   wire [16:0] sub_w = {1'b0, operand_a} - {1'b0, operand_b};
   wire half_add = half12(operand_a, operand_b, 1'b0);
   wire half_sub = half12(operand_a, operand_b, 1'b1);
   wire cin = condition_code_register_q[`CPDEC_CC_C];
   wire [8:0] xadd = ext_op(operand_a[7:0], operand_b[7:0], cin, 1'b0);
   wire [8:0] xsub = ext_op(operand_a[7:0], operand_b[7:0], cin, 1'b1);
   wire hin = condition_code_register_q[`CPDEC_CC_H];
   wire lo_adj = hin || (operand_a[3:0] > 4'h9);
   wire hi_adj = cin || (operand_a[7:4] > 4'h9)
      || (operand_a[7:4] == 4'h9 && operand_a[3:0] > 4'h9);
   wire [7:0] dadj = {hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};
   wire [8:0] daa_sum = {1'b0, operand_a[7:0]} + {1'b0, dadj};
   wire [15:0] blk_states = {8'h00, count_register_low_byte} * `CPDEC_BLK_MUL
      + `CPDEC_BLK_ADD;

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (issue) begin
               if (cls == CL_CALL)
                  st_d = ST_CALL;
               else if (cls == CL_RTS)
                  st_d = ST_RET;
               else if (cls == CL_RTE)
                  st_d = ST_RTE_CC;
               else if (cls == CL_SYNC)
                  st_d = ST_SYNC;
            end
         end
         ST_CALL: st_d = ST_IDLE;
         ST_RET: st_d = ST_IDLE;
         ST_RTE_CC: st_d = ST_RTE_PC;
         ST_RTE_PC: st_d = ST_IDLE;
         ST_SYNC: st_d = sync_done ? ST_IDLE : ST_SYNC;
         ST_COUNT: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   // stack port drive; reads take data same cycle from stack_rdata
   always @* begin
      stack_we = 1'b0;
      stack_addr = sp_q;
      stack_wdata = 16'h0000;
      case (st_q)
         ST_CALL: begin
            stack_we = 1'b1;
            stack_addr = sp_q;
            stack_wdata = next_pc;
         end
         default: begin
            stack_we = 1'b0;
         end
      endcase
   end

   always @(posedge clock) begin
      if (rst) begin
         st_q <= ST_IDLE;
         op_class_q <= CL_OTHER;
         is_sync_move_q <= 1'b0;
         is_data_move_q <= 1'b0;
         condition_code_register_q <= `CPDEC_CC_RESET;
         result_q <= 16'h0000;
         states_q <= 16'h0000;
         sp_q <= `CPDEC_SP_RESET;
         pc_q <= 16'h0000;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         done_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (issue) begin
                  op_class_q <= cls;
                  is_sync_move_q <= (cls == CL_SYNC);
                  is_data_move_q <= (cls == CL_MOVE);
                  states_q <= weigh(4'd1, 4'd0, 4'd0, 4'd0, 4'd0, 4'd0);
                  pc_q <= next_pc;
                  done_q <= (cls != CL_CALL) && (cls != CL_RTS)
                     && (cls != CL_RTE) && (cls != CL_SYNC);
                  case (cls)
                     CL_ADDW: begin
                        result_q <= add_w[15:0];
                        condition_code_register_q[`CPDEC_CC_H] <= half_add;
                        condition_code_register_q[`CPDEC_CC_C] <= add_w[16];
                     end
                     CL_SUBW: begin
                        result_q <= sub_w[15:0];
                        condition_code_register_q[`CPDEC_CC_H] <= half_sub;
                        condition_code_register_q[`CPDEC_CC_C] <= sub_w[16];
                     end
                     CL_EXTADD: begin
                        result_q <= {8'h00, xadd[7:0]};
                        condition_code_register_q[`CPDEC_CC_C] <= xadd[8];
                        if (xadd[7:0] != 8'h00)
                           condition_code_register_q[`CPDEC_CC_Z] <= 1'b0;
                     end
                     CL_EXTSUB: begin
                        result_q <= {8'h00, xsub[7:0]};
                        condition_code_register_q[`CPDEC_CC_C] <= xsub[8];
                        if (xsub[7:0] != 8'h00)
                           condition_code_register_q[`CPDEC_CC_Z] <= 1'b0;
                     end
                     CL_DAA: begin
                        result_q <= {8'h00, daa_sum[7:0]};
                        condition_code_register_q[`CPDEC_CC_C] <= hi_adj;
                     end
                     CL_DAS: begin
                        result_q <= {8'h00, operand_a[7:0] - dadj};
                        condition_code_register_q[`CPDEC_CC_C] <= hi_adj;
                     end
                     CL_DIVU: begin
                        if (operand_b[7:0] != 8'h00)
                           result_q <= div_pack(operand_a, operand_b[7:0]);
                        condition_code_register_q[`CPDEC_CC_N] <= operand_b[7];
                        condition_code_register_q[`CPDEC_CC_V] <= (operand_b[7:0] == 8'h00);
                     end
                     CL_BLKMOVE: states_q <= blk_states;
                     CL_BRANCH: states_q <= weigh(4'd2, 4'd0, 4'd0, 4'd0, 4'd0, 4'd0);
                     default: result_q <= result_q;
                  endcase
                  if (cls == CL_CALL)
                     sp_q <= sp_q - `CPDEC_SP_STEP;
               end
            end
            ST_CALL: begin
               pc_q <= target_addr;
               states_q <= weigh(4'd2, 4'd0, 4'd1, 4'd0, 4'd0, 4'd0);
               done_q <= 1'b1;
            end
            ST_RET: begin
               pc_q <= stack_rdata;
               sp_q <= sp_q + `CPDEC_SP_STEP;
               states_q <= weigh(4'd2, 4'd0, 4'd1, 4'd0, 4'd0, 4'd1);
               done_q <= 1'b1;
            end
            ST_RTE_CC: begin
               condition_code_register_q <= stack_rdata[7:0];
               sp_q <= sp_q + `CPDEC_SP_STEP;
            end
            ST_RTE_PC: begin
               pc_q <= stack_rdata;
               sp_q <= sp_q + `CPDEC_SP_STEP;
               states_q <= weigh(4'd2, 4'd0, 4'd2, 4'd0, 4'd0, 4'd1);
               done_q <= 1'b1;
            end
            ST_SYNC: begin
               if (sync_done) begin
                  // length depends on peripheral phase, not fixed
                  states_q <= weigh(4'd2, 4'd0, 4'd0, 4'd0, 4'd0, 4'd0)
                     + {{(16-SYNC_CW){1'b0}}, sync_waited};
                  done_q <= 1'b1;
               end
            end
            default: done_q <= 1'b0;
         endcase
      end
   end
endmodule // cpdec_core

// >>> rtl/cpdec_sync_wait.v
// counts clock cycles until a slow peripheral clock falling edge ends a synchronised move
`timescale 1ns/1ns
module cpdec_sync_wait #(
   parameter CW = 8
) (
   input wire clock,
   input wire rst,
   input wire start,
   input wire periph_clk_in,
   output wire done,
   output reg [CW-1:0] waited_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg busy_q;
   // two-stage synchroniser; s2 and the s3 delay stage feed the falling-edge detect
   always @(posedge clock) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= periph_clk_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   wire fall = s3_q & ~s2_q;
   assign done = busy_q & fall;
   always @(posedge clock) begin
      if (rst) begin
         busy_q <= 1'b0;
         waited_q <= {CW{1'b0}};
      end else if (start) begin
         busy_q <= 1'b1;
         waited_q <= {CW{1'b0}};
      end else if (busy_q) begin
         waited_q <= waited_q + 1'b1;
         if (fall)
            busy_q <= 1'b0;
      end
   end
endmodule // cpdec_sync_wait

// >>> sim/cpdec_core_checker.sv
// assertion checker for the opcode decoder core
`timescale 1ns/1ns
`include "cpdec_map.vh"
module cpdec_core_checker #(
   parameter SYNC_CW = 8
) (
   input wire clock,
   input wire rst,
   input wire issue,
   input wire [15:0] instr_word,
   input wire [15:0] operand_a,
   input wire [15:0] operand_b,
   input wire [7:0] count_register_low_byte,
   input wire [15:0] target_addr,
   input wire [15:0] next_pc,
   input wire [15:0] stack_rdata,
   input wire periph_clk_in,
   input wire [7:0] op_class_q,
   input wire is_sync_move_q,
   input wire is_data_move_q,
   input wire [7:0] condition_code_register_q,
   input wire [15:0] result_q,
   input wire [15:0] states_q,
   input wire [15:0] sp_q,
   input wire [15:0] pc_q,
   input wire stack_we,
   input wire [15:0] stack_addr,
   input wire [15:0] stack_wdata,
   input wire busy,
   input wire done_q
);
   reg [15:0] sp_cap_q;
   reg cap_z_q;
   reg cap_c_q;
   wire [7:0] condition_code_register = condition_code_register_q;
   wire [8:0] ext_sum = {1'b0, operand_b[7:0]} + {1'b0, operand_a[7:0]} + {8'h00, cap_c_q};
   wire add_h = ({1'b0, operand_a[11:0]} + {1'b0, operand_b[11:0]}) > 13'h0FFF;
   wire ext_z = (ext_sum[7:0] == 8'h00) ? cap_z_q : 1'b0;
   wire daa_c = cap_c_q || (operand_a[7:0] > 8'h99);
   wire [15:0] blk_st = {6'h00, count_register_low_byte, 2'b00} + 16'h0008;
   // flags and stack pointer as they were when the instruction was taken
   always @(posedge clock) begin
      if (rst) begin
         sp_cap_q <= 16'h0000;
         cap_z_q <= 1'b0;
         cap_c_q <= 1'b0;
      end else if (issue && !busy) begin
         sp_cap_q <= sp_q;
         cap_z_q <= condition_code_register[`CPDEC_CC_Z];
         cap_c_q <= condition_code_register[`CPDEC_CC_C];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_take(op);
      issue && !busy && instr_word[15:8] == op;
   endsequence
   sequence s_done(ok);
      ##[1:4] (done_q && ok);
   endsequence
   property p_addw_h;
      s_take(`CPDEC_OP_ADDW) |-> s_done(condition_code_register[`CPDEC_CC_H] == add_h);
   endproperty
   a_addw_h: assert property (p_addw_h) else $error("word add half carry wrong");
   property p_ext_z;
      s_take(`CPDEC_OP_EXTADD_R) |-> s_done(condition_code_register[`CPDEC_CC_Z] == ext_z);
   endproperty
   a_ext_z: assert property (p_ext_z) else $error("extended add zero flag wrong");
   property p_daa_c;
      s_take(`CPDEC_OP_DAA) |-> s_done(condition_code_register[`CPDEC_CC_C] == daa_c);
   endproperty
   a_daa_c: assert property (p_daa_c) else $error("decimal adjust carry wrong");
   property p_blk;
      s_take(`CPDEC_OP_BLKMOVE) |-> s_done(states_q == blk_st && op_class_q == 8'h0E);
   endproperty
   a_blk: assert property (p_blk) else $error("block move state count wrong");
   property p_divu;
      s_take(`CPDEC_OP_DIVU) |-> s_done(condition_code_register[`CPDEC_CC_N] == operand_b[7]
         && condition_code_register[`CPDEC_CC_V] == (operand_b[7:0] == 8'h00));
   endproperty
   a_divu: assert property (p_divu) else $error("divide flags wrong");
   property p_call;
      s_take(`CPDEC_OP_JSR_A) |=> (sp_q == sp_cap_q - 16'h0002 && stack_we
         && stack_addr == sp_q && stack_wdata == next_pc) ##[0:3] (done_q && pc_q == target_addr);
   endproperty
   a_call: assert property (p_call) else $error("call sequence wrong");
   property p_rte;
      s_take(`CPDEC_OP_RTE) |-> ##[2:5] (done_q && sp_q == sp_cap_q + 16'h0004);
   endproperty
   a_rte: assert property (p_rte) else $error("exception return stack wrong");
   property p_sync;
   // a falling phase already in the synchroniser ends the move two edges on
      issue && !busy && instr_word == 16'h6A00 |=> !done_q
         ##[1:400] (done_q && is_sync_move_q && op_class_q == 8'h02);
   endproperty
   a_sync: assert property (p_sync) else $error("sync move timing wrong");
   property p_branch;
      issue && !busy && instr_word[15:12] == `CPDEC_HI_BRANCH
         |-> s_done(op_class_q == 8'h03 && states_q == 16'h0004);
   endproperty
   a_branch: assert property (p_branch) else $error("branch decode wrong");
   property p_push;
      s_take(8'h6D) |-> s_done(is_data_move_q && !is_sync_move_q);
   endproperty
   a_push: assert property (p_push) else $error("push decode wrong");
endmodule // cpdec_core_checker
bind cpdec_core cpdec_core_checker #(.SYNC_CW(SYNC_CW)) chk_u (
   .clock(clock), .rst(rst), .issue(issue), .instr_word(instr_word),
   .operand_a(operand_a), .operand_b(operand_b), .target_addr(target_addr),
   .count_register_low_byte(count_register_low_byte), .next_pc(next_pc),
   .stack_rdata(stack_rdata), .periph_clk_in(periph_clk_in), .op_class_q(op_class_q),
   .is_sync_move_q(is_sync_move_q), .is_data_move_q(is_data_move_q), .result_q(result_q),
   .condition_code_register_q(condition_code_register_q), .states_q(states_q),
   .sp_q(sp_q), .pc_q(pc_q), .stack_we(stack_we), .stack_addr(stack_addr),
   .stack_wdata(stack_wdata), .busy(busy), .done_q(done_q));

// >>> sim/cpdec_far_side.sv
// stack memory and slow peripheral clock facing the decoder core
`timescale 1ns/1ns
module cpdec_far_side (
   input wire clock,
   input wire stack_we,
   input wire [15:0] stack_addr,
   input wire [15:0] stack_wdata,
   input wire pre_we,
   input wire [15:0] pre_addr,
   input wire [15:0] pre_data,
   output wire [15:0] stack_rdata,
   output reg periph_clk_in = 1'b0
);
   reg [15:0] mem_q [0:15];
   reg [2:0] div_q = 3'h0;
   // only a small window is decoded, enough for a few nested frames
   assign stack_rdata = mem_q[stack_addr[4:1]];
   always @(posedge clock) begin
      if (stack_we)
         mem_q[stack_addr[4:1]] <= stack_wdata;
      if (pre_we)
         mem_q[pre_addr[4:1]] <= pre_data;
      // slow clock runs free, as the real one does
      div_q <= (div_q == 3'h6) ? 3'h0 : div_q + 3'h1;
      if (div_q == 3'h6)
         periph_clk_in <= ~periph_clk_in;
   end
endmodule // cpdec_far_side

// >>> sim/testbench.sv
// self-checking bench for the opcode decoder core
`timescale 1ns/1ns
`include "cpdec_map.vh"
module testbench;
   reg clock = 1'b0;
   reg rst = 1'b1;
   reg issue = 1'b0;
   reg pre_we = 1'b0;
   reg [15:0] instr_word = 16'h0000;
   reg [15:0] operand_a = 16'h0000;
   reg [15:0] operand_b = 16'h0000;
   reg [7:0] count_register_low_byte = 8'h00;
   reg [15:0] target_addr = 16'h0000;
   reg [15:0] next_pc = 16'h0000;
   reg [15:0] pre_addr = 16'h0000;
   reg [15:0] pre_data = 16'h0000;
   wire [15:0] stack_rdata, result_q, states_q, sp_q, pc_q, stack_addr, stack_wdata;
   wire [7:0] op_class_q, ccr_q;
   wire periph_clk_in, is_sync_move_q, is_data_move_q, stack_we, busy, done_q;
   integer err_count = 0;
   integer checks = 0;
   integer i;
   reg [31:0] tab [0:16];
   reg [31:0] t;
   reg [15:0] a, b;
   reg [2:0] e;
   reg [7:0] nb;
   always #10 clock = ~clock;
   cpdec_core #(.SYNC_CW(8)) dut_u (.clock(clock), .rst(rst), .issue(issue),
      .instr_word(instr_word), .operand_a(operand_a), .operand_b(operand_b),
      .count_register_low_byte(count_register_low_byte), .target_addr(target_addr),
      .next_pc(next_pc), .stack_rdata(stack_rdata), .periph_clk_in(periph_clk_in),
      .op_class_q(op_class_q), .is_sync_move_q(is_sync_move_q), .result_q(result_q),
      .is_data_move_q(is_data_move_q), .condition_code_register_q(ccr_q),
      .states_q(states_q), .sp_q(sp_q), .pc_q(pc_q), .stack_we(stack_we),
      .stack_addr(stack_addr), .stack_wdata(stack_wdata), .busy(busy), .done_q(done_q));
   cpdec_far_side far_u (.clock(clock), .stack_we(stack_we), .stack_addr(stack_addr),
      .stack_wdata(stack_wdata), .pre_we(pre_we), .pre_addr(pre_addr),
      .pre_data(pre_data), .stack_rdata(stack_rdata), .periph_clk_in(periph_clk_in));
   task complete_run;
      begin
         if (err_count == 0 && checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task check(input [15:0] ex, input [15:0] got);
      begin
         checks = checks + 1;
         if (got !== ex) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, ex);
         end
      end
   endtask
   // sample at the falling edge so register updates have landed
   task wait_done;
      integer n;
      begin
         n = 0;
         @(negedge clock);
         while (done_q !== 1'b1 && n < 500) begin
            @(negedge clock);
            n = n + 1;
         end
         check(16'h0001, {15'h0000, done_q});
         @(posedge clock);
      end
   endtask
   task run(input [15:0] iw, input [7:0] cls);
      begin
         instr_word <= iw;
         issue <= 1'b1;
         @(posedge clock);
         issue <= 1'b0;
         wait_done;
         check({8'h00, cls}, {8'h00, op_class_q});
      end
   endtask
   function [2:0] exp_nvh(input [15:0] iw, input [15:0] s, input [15:0] d);
      begin
         exp_nvh = {d[7], d[7:0] == 8'h00, iw[12] ? (s[11:0] < d[11:0])
            : (({1'b0, s[11:0]} + {1'b0, d[11:0]}) > 13'h0FFF)};
      end
   endfunction
   initial begin
      repeat (20000) @(posedge clock);
      err_count = err_count + 1;
      complete_run;
   end
   initial begin
      i = $urandom(32'h4484);
      tab[0] = 32'h0912_0702;
      tab[1] = 32'h1934_0802;
      tab[2] = 32'h0E12_0902;
      tab[3] = 32'h9312_0902;
      tab[4] = 32'h1E12_0A02;
      tab[5] = 32'hB312_0A02;
      tab[6] = 32'h0F02_0B02;
      tab[7] = 32'h1F02_0C02;
      tab[8] = 32'h5112_0DFF;
      tab[9] = 32'h4010_0304;
      tab[10] = 32'h4110_0304;
      tab[11] = 32'h4410_0304;
      tab[12] = 32'h4510_0304;
      tab[13] = 32'h6A80_01FF;
      tab[14] = 32'h6A18_01FF;
      tab[15] = 32'h6DF0_01FF;
      tab[16] = 32'h6A00_02FF;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check(16'h0080, {8'h00, ccr_q});
      check(16'h0000, sp_q);
      // first pass forces a zero divisor, second a negative one
      for (i = 0; i < 68; i = i + 1) begin
         t = tab[i % 17];
         {a, b} = $urandom;
         b = (i < 17) ? 16'h0000 : (i < 34) ? 16'h0080 : b;
         operand_a <= a;
         operand_b <= b;
         run(t[31:16], t[15:8]);
         e = exp_nvh(t[31:16], a, b);
         if (t[7:0] != 8'hFF)
            check({8'h00, t[7:0]}, states_q);
         if (t[31:24] == `CPDEC_OP_DIVU)
            check({14'h0, e[2:1]}, {14'h0, ccr_q[`CPDEC_CC_N], ccr_q[`CPDEC_CC_V]});
         if (t[31:24] == `CPDEC_OP_ADDW || t[31:24] == `CPDEC_OP_SUBW)
            check({15'h0, e[0]}, {15'h0, ccr_q[`CPDEC_CC_H]});
         if (t[31:24] == `CPDEC_OP_ADDW)
            check(a + b, result_q);
         if (t[31:24] == `CPDEC_OP_SUBW)
            check(a - b, result_q);
      end
      for (i = 0; i < 3; i = i + 1) begin
         nb = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $urandom % 256;
         count_register_low_byte <= nb;
         run({`CPDEC_OP_BLKMOVE, 8'h5C}, 8'h0E);
         check({6'h00, nb, 2'b00} + 16'h0008, states_q);
      end
      // call held two edges: the second request lands while busy
      target_addr <= 16'h0A40;
      next_pc <= 16'h0124;
      instr_word <= {`CPDEC_OP_JSR_A, 8'h00};
      issue <= 1'b1;
      @(posedge clock);
      instr_word <= 16'h0000;
      @(posedge clock);
      issue <= 1'b0;
      wait_done;
      check(16'h0004, {8'h00, op_class_q});
      check(16'h0A40, pc_q);
      check(16'hFFFE, sp_q);
      run({`CPDEC_OP_RTS, 8'h70}, 8'h05);
      check(16'h0124, pc_q);
      check(16'h0000, sp_q);
      run({`CPDEC_OP_JSR_A, 8'h00}, 8'h04);
      pre_we <= 1'b1;
      pre_addr <= 16'hFFFE;
      pre_data <= 16'h002B;
      @(posedge clock);
      pre_addr <= 16'h0000;
      pre_data <= 16'h3456;
      @(posedge clock);
      pre_we <= 1'b0;
      run({`CPDEC_OP_RTE, 8'h70}, 8'h06);
      check(16'h002B, {8'h00, ccr_q});
      check(16'h3456, pc_q);
      check(16'h0002, sp_q);
      complete_run;
   end
endmodule // testbench
